// ### core/lfe_top.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module lfe_top
    import lfe_pkg::*;
#(
    parameter int unsigned FAST_BASE = FAST_BASE_CYC,   // fast half-period base, cycles
    parameter int unsigned SLOW_BASE = SLOW_BASE_CYC    // slow half-period base, cycles
) (
    input  wire logic        core_clk_i,        // system clock
    input  wire logic        rst_b_i,           // async reset, active low
    input  wire logic        clk_en_i,          // freezes all state when low
    input  wire logic [3:0]  reg_addr_i,        // register word address
    input  wire logic [15:0] reg_wdata_i,       // write data
    input  wire logic        reg_wr_i,          // write strobe
    input  wire logic        reg_rd_i,          // read strobe
    output logic      [15:0] reg_rdata_o,       // read data, cycle after strobe
    input  wire logic        link_up_slow_speed_i,  // link up at 10M
    input  wire logic        link_up_mid_speed_i,   // link up at 100M
    input  wire logic        link_up_gigabit_i,     // link up at 1000M
    input  wire logic        transmit_activity_i,   // tx activity pulse
    input  wire logic        receive_activity_i,    // rx activity pulse
    input  wire logic        collision_i,           // half-duplex collision
    input  wire logic        eee_mode_i,            // low-power mode active
    input  wire logic        aneg_busy_i,           // auto-negotiation running
    input  wire logic        diag_active_i,         // self-test or cable diagnostics
    input  wire logic        media_fiber_i,         // fiber interface active
    output logic      [2:0]  led_o              // led pins, active high
);
    // walk and antiphase logic are written for exactly three LEDs
    if (NUM_LEDS != 3 || FAST_BASE < 2 || SLOW_BASE < 2) begin : g_bad_param
        $error("lfe_top: unsupported parameter values");
    end

    logic [15:0] led_cfg_r [NUM_LEDS];
    logic [15:0] cplx_lo_r;
    logic [15:0] cplx_hi_r;
    logic [15:0] led_ctrl_r;
    logic [15:0] rdata_r;

    // register writes
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_LEDS; i++) led_cfg_r[i] <= RST_LED_CFG;
            cplx_lo_r  <= RST_COMPLEX_LO;
            cplx_hi_r  <= RST_COMPLEX_HI;
            led_ctrl_r <= RST_LED_CTRL;
        end else if (clk_en_i && reg_wr_i) begin
            if (reg_addr_i == ADDR_LED_CFG0) begin
                led_cfg_r[0] <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_LED_CFG1) begin
                led_cfg_r[1] <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_LED_CFG2) begin
                led_cfg_r[2] <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_COMPLEX_LO) begin
                cplx_lo_r <= {14'h0000, reg_wdata_i[1:0]};
            end else if (reg_addr_i == ADDR_COMPLEX_HI) begin
                cplx_hi_r <= {4'h0, reg_wdata_i[11:8], reg_wdata_i[7:4], 3'h0, reg_wdata_i[0]};
            end else if (reg_addr_i == ADDR_LED_CTRL) begin
                led_ctrl_r <= {9'h000, reg_wdata_i[6:4], 1'b0, reg_wdata_i[2:0]};
            end
        end
    end

    // sources synchronised through two flops
    logic [9:0] src_meta_r;
    logic [9:0] src_sync_r;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_meta_r <= 10'h000;
            src_sync_r <= 10'h000;
        end else if (clk_en_i) begin
            src_meta_r <= {media_fiber_i, diag_active_i, aneg_busy_i, eee_mode_i, collision_i,
                           receive_activity_i, transmit_activity_i, link_up_gigabit_i,
                           link_up_mid_speed_i, link_up_slow_speed_i};
            src_sync_r <= src_meta_r;
        end
    end

    // selectable condition from a 4-bit code
    function automatic logic src_sel(input logic [3:0] code, input logic [9:0] s);
        logic r;
        r = 1'b0;
        case (code)
            LFE_SRC_LINK_LO:  r = s[0];
            LFE_SRC_LINK_MID: r = s[1];
            LFE_SRC_LINK_GIG: r = s[2];
            LFE_SRC_LINK_ANY: r = s[0] | s[1] | s[2];
            LFE_SRC_TX_ACT:   r = s[3];
            LFE_SRC_RX_ACT:   r = s[4];
            LFE_SRC_ACT:      r = s[3] | s[4];
            LFE_SRC_COL:      r = s[5];
            LFE_SRC_EEE:      r = s[6];
            LFE_SRC_ANEG:     r = s[7];
            LFE_SRC_DIAG:     r = s[8];
            LFE_SRC_COPPER:   r = ~s[9] & (s[0] | s[1] | s[2]);
            LFE_SRC_FIBER:    r = s[9];
            default:          r = 1'b0;
        endcase
        return r;
    endfunction : src_sel

    logic [3:0]  fast_freq_select;
    logic [3:0]  slow_freq_select;
    logic [31:0] fast_half;
    logic [31:0] slow_half;
    assign fast_freq_select = cplx_hi_r[POS_FFS +: 4];
    assign slow_freq_select = cplx_hi_r[POS_SFS +: 4];
    assign fast_half = 32'(FAST_BASE) << fast_freq_select[2:0];
    assign slow_half = 32'(SLOW_BASE) << slow_freq_select[2:0];

    logic [31:0] fast_cnt_r;
    logic [31:0] slow_cnt_r;
    logic        fast_ph_r;
    logic        slow_ph_r;
    logic        fast_tick;
    assign fast_tick = (fast_cnt_r >= fast_half - 32'd1);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fast_cnt_r <= 32'd0;
            fast_ph_r  <= 1'b0;
        end else if (clk_en_i) begin
            if (fast_tick) begin
                fast_cnt_r <= 32'd0;
                fast_ph_r  <= ~fast_ph_r;
            end else begin
                fast_cnt_r <= fast_cnt_r + 32'd1;
            end
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slow_cnt_r <= 32'd0;
            slow_ph_r  <= 1'b0;
        end else if (clk_en_i) begin
            if (slow_cnt_r >= slow_half - 32'd1) begin
                slow_cnt_r <= 32'd0;
                slow_ph_r  <= ~slow_ph_r;
            end else begin
                slow_cnt_r <= slow_cnt_r + 32'd1;
            end
        end
    end

    logic [1:0] walk_pos_r;
    logic       walk_up_r;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            walk_pos_r <= 2'd0;
            walk_up_r  <= 1'b1;
        end else if (clk_en_i && fast_tick) begin
            if (walk_up_r) begin
                if (walk_pos_r == 2'd2) begin
                    walk_pos_r <= 2'd1;
                    walk_up_r  <= 1'b0;
                end else begin
                    walk_pos_r <= walk_pos_r + 2'd1;
                end
            end else begin
                if (walk_pos_r == 2'd0) begin
                    walk_pos_r <= 2'd1;
                    walk_up_r  <= 1'b1;
                end else begin
                    walk_pos_r <= walk_pos_r - 2'd1;
                end
            end
        end
    end

    // pulse stretcher per LED: on for one fast half-period, then off for one
    typedef enum logic [1:0] {
        LFE_P_IDLE = 2'b00,
        LFE_P_ON   = 2'b01,
        LFE_P_OFF  = 2'b10
    } lfe_pulse_e;
    lfe_pulse_e  pst_r   [NUM_LEDS];
    logic [31:0] pcnt_r  [NUM_LEDS];
    logic [2:0]  evt_prev_r;
    logic [2:0]  evt_now;
    logic [2:0]  evt_rise;
    logic [2:0]  led_nxt;

    always_comb begin
        for (int i = 0; i < NUM_LEDS; i++) begin
            evt_now[i] = src_sel(led_cfg_r[i][POS_PULSE +: 4], src_sync_r);
        end
    end
    assign evt_rise = evt_now & ~evt_prev_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            evt_prev_r <= 3'h0;
            for (int i = 0; i < NUM_LEDS; i++) begin
                pst_r[i]  <= LFE_P_IDLE;
                pcnt_r[i] <= 32'd0;
            end
        end else if (clk_en_i) begin
            evt_prev_r <= evt_now;
            for (int i = 0; i < NUM_LEDS; i++) begin
                case (pst_r[i])
                    // only idle accepts a new event
                    LFE_P_IDLE: begin
                        if (evt_rise[i]) begin
                            pst_r[i]  <= LFE_P_ON;
                            pcnt_r[i] <= 32'd0;
                        end
                    end
                    LFE_P_ON: begin
                        if (pcnt_r[i] >= fast_half - 32'd1) begin
                            pst_r[i]  <= LFE_P_OFF;
                            pcnt_r[i] <= 32'd0;
                        end else begin
                            pcnt_r[i] <= pcnt_r[i] + 32'd1;
                        end
                    end
                    LFE_P_OFF: begin
                        if (pcnt_r[i] >= fast_half - 32'd1) begin
                            pst_r[i]  <= LFE_P_IDLE;
                            pcnt_r[i] <= 32'd0;
                        end else begin
                            pcnt_r[i] <= pcnt_r[i] + 32'd1;
                        end
                    end
                    default: pst_r[i] <= LFE_P_IDLE;
                endcase
            end
        end
    end

    // output selection
    always_comb begin
        for (int i = 0; i < NUM_LEDS; i++) begin
            // direct priority chain: pulse, then fast, slow, steady on; complex modes and external drive override it
            if (pst_r[i] != LFE_P_IDLE) begin
                led_nxt[i] = (pst_r[i] == LFE_P_ON);
            end else if (src_sel(led_cfg_r[i][POS_FAST +: 4], src_sync_r)) begin
                led_nxt[i] = fast_ph_r;
            end else if (src_sel(led_cfg_r[i][POS_SLOW +: 4], src_sync_r)) begin
                led_nxt[i] = slow_ph_r;
            end else if (src_sel(led_cfg_r[i][POS_ON +: 4], src_sync_r)) begin
                led_nxt[i] = 1'b1;
            end else begin
                led_nxt[i] = 1'b0;
            end
            if (cplx_lo_r[POS_ALLF]) begin
                led_nxt[i] = fast_ph_r ^ i[0];
            end else if (cplx_lo_r[POS_WALK]) begin
                led_nxt[i] = (walk_pos_r == 2'(i));
            end else if (cplx_hi_r[POS_INVS]) begin
                led_nxt[i] = (walk_pos_r != 2'(i));
            end
            if (!led_ctrl_r[POS_ICS + i]) begin
                led_nxt[i] = led_ctrl_r[POS_DDB + i];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_o <= 3'h0;
        end else if (clk_en_i) begin
            led_o <= led_nxt;
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 16'h0000;
        end else if (clk_en_i) begin
            if (!reg_rd_i) begin
                rdata_r <= 16'h0000;
            end else if (reg_addr_i == ADDR_LED_CFG0) begin
                rdata_r <= led_cfg_r[0];
            end else if (reg_addr_i == ADDR_LED_CFG1) begin
                rdata_r <= led_cfg_r[1];
            end else if (reg_addr_i == ADDR_LED_CFG2) begin
                rdata_r <= led_cfg_r[2];
            end else if (reg_addr_i == ADDR_COMPLEX_LO) begin
                rdata_r <= cplx_lo_r;
            end else if (reg_addr_i == ADDR_COMPLEX_HI) begin
                rdata_r <= cplx_hi_r;
            end else if (reg_addr_i == ADDR_LED_CTRL) begin
                rdata_r <= led_ctrl_r;
            end else if (reg_addr_i == ADDR_STATUS) begin
                rdata_r <= {9'h000, led_o, 1'b0, walk_pos_r, fast_ph_r};
            end else begin
                rdata_r <= 16'h0000;
            end
        end
    end
    assign reg_rdata_o = rdata_r;

    // checks
    AST_EXT_DRIVE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i && !led_ctrl_r[POS_ICS] |=> led_o[0] == $past(led_ctrl_r[POS_DDB]))
        else $error("external drive bit not on LED0");
    AST_ALL_FLASH: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i && cplx_lo_r[POS_ALLF] && led_ctrl_r[1:0] == 2'b11
        |=> led_o[0] != led_o[1])
        else $error("all_flash LEDs not in antiphase");
    AST_WALK_ONEHOT: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i && !cplx_lo_r[POS_ALLF] && cplx_lo_r[POS_WALK] && led_ctrl_r[2:0] == 3'h7
        |=> $onehot(led_o))
        else $error("walking light not one-hot");
    AST_INV_SWEEP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i && cplx_lo_r[1:0] == 2'b00 && cplx_hi_r[POS_INVS] && led_ctrl_r[2:0] == 3'h7
        |=> $onehot(~led_o))
        else $error("inverted sweep not one-cold");
    AST_WALK_RANGE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        walk_pos_r != 2'd3)
        else $error("walk position out of range");
    AST_PULSE_NORESTART: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i && pst_r[0] == LFE_P_ON && pcnt_r[0] != 32'd0 |=> pcnt_r[0] != 32'd0
        || pst_r[0] == LFE_P_OFF)
        else $error("pulse restarted while running");
    sequence s_pulse_arm;
        clk_en_i && pst_r[0] == LFE_P_IDLE && evt_rise[0];
    endsequence
    sequence s_pulse_lit;
        pst_r[0] == LFE_P_ON;
    endsequence
    AST_PULSE_START: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_pulse_arm |=> s_pulse_lit)
        else $error("event did not start pulse");
    AST_STEADY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i && led_ctrl_r[POS_ICS] && cplx_lo_r[1:0] == 2'b00 && !cplx_hi_r[POS_INVS]
        && pst_r[0] == LFE_P_IDLE && !src_sel(led_cfg_r[0][POS_FAST +: 4], src_sync_r)
        && !src_sel(led_cfg_r[0][POS_SLOW +: 4], src_sync_r)
        && src_sel(led_cfg_r[0][POS_ON +: 4], src_sync_r) |=> led_o[0])
        else $error("steady_on source set but LED0 dark");
endmodule : lfe_top

// ### core/lfe_pkg.sv
package lfe_pkg;
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned NUM_LEDS        = 3;

    // event source selection codes for a direct-function field
    typedef enum logic [3:0] {
        LFE_SRC_NONE     = 4'h0,
        LFE_SRC_LINK_LO  = 4'h1,
        LFE_SRC_LINK_MID = 4'h2,
        LFE_SRC_LINK_GIG = 4'h3,
        LFE_SRC_LINK_ANY = 4'h4,
        LFE_SRC_TX_ACT   = 4'h5,
        LFE_SRC_RX_ACT   = 4'h6,
        LFE_SRC_ACT      = 4'h7,
        LFE_SRC_COL      = 4'h8,
        LFE_SRC_EEE      = 4'h9,
        LFE_SRC_ANEG     = 4'hA,
        LFE_SRC_DIAG     = 4'hB,
        LFE_SRC_COPPER   = 4'hC,
        LFE_SRC_FIBER    = 4'hD
    } lfe_src_e;

    // register map (word addresses)
    localparam logic [3:0] ADDR_LED_CFG0    = 4'h0;
    localparam logic [3:0] ADDR_LED_CFG1    = 4'h1;
    localparam logic [3:0] ADDR_LED_CFG2    = 4'h2;
    localparam logic [3:0] ADDR_COMPLEX_LO  = 4'h3;
    localparam logic [3:0] ADDR_COMPLEX_HI  = 4'h4;
    localparam logic [3:0] ADDR_LED_CTRL    = 4'h5;
    localparam logic [3:0] ADDR_STATUS      = 4'h6;

    // per_led_cfg field positions
    localparam int unsigned POS_PULSE = 0;
    localparam int unsigned POS_FAST  = 4;
    localparam int unsigned POS_SLOW  = 8;
    localparam int unsigned POS_ON    = 12;
    // complex_cfg_low: all_flash, walk enable bits
    localparam int unsigned POS_ALLF  = 0;
    localparam int unsigned POS_WALK  = 1;
    // complex_cfg_high: inverted_sweep enable, freq selects
    localparam int unsigned POS_INVS  = 0;
    localparam int unsigned POS_FFS   = 4;
    localparam int unsigned POS_SFS   = 8;
    // led control: internal_control_select [2:0], direct_drive_bit [6:4]
    localparam int unsigned POS_ICS   = 0;
    localparam int unsigned POS_DDB   = 4;

    localparam logic [15:0] RST_LED_CFG    = 16'h0000;
    localparam logic [15:0] RST_COMPLEX_LO = 16'h0000;
    localparam logic [15:0] RST_COMPLEX_HI = 16'h0110;
    localparam logic [15:0] RST_LED_CTRL   = 16'h0007;

    // half-period of a flash for frequency select code n: base * 2^(n mod 8) cycles
    localparam int unsigned FAST_BASE_NS    = 8_000_000;
    localparam int unsigned SLOW_BASE_NS    = 32_000_000;
    localparam int unsigned FAST_BASE_CYC   = FAST_BASE_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned SLOW_BASE_CYC   = SLOW_BASE_NS / (1_000_000_000 / CLK_HZ);
endpackage : lfe_pkg

// ### test/lfe_led_model.sv
`timescale 1ns/1ps
module lfe_led_model (
    input  wire logic             core_clk_i, // bench clock
    input  wire logic             clr_i,      // restarts the lit counts
    input  wire logic [2:0]       led_i,      // led pins of the block
    output logic      [2:0][15:0] lit_cnt_o   // cycles each led was lit
);
    always_ff @(posedge core_clk_i) begin
        for (int k = 0; k < 3; k++) begin
            if (clr_i) begin
                lit_cnt_o[k] <= 16'h0000;
            end else if (led_i[k] === 1'b1) begin
                lit_cnt_o[k] <= lit_cnt_o[k] + 16'h0001;
            end
        end
    end
endmodule : lfe_led_model

// ### test/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
    import lfe_pkg::*;
    // short bases keep flash periods to a few cycles
    localparam int unsigned FB = 4;
    localparam int unsigned SB = 16;
    localparam int SRC_BIT [13] = '{0, 1, 2, 0, 3, 4, 3, 5, 6, 7, 8, 2, 9};
    logic             clk   = 1'b0;
    logic             rst_b = 1'b0;
    logic [3:0]       addr  = 4'h0;
    logic [15:0]      wdata = 16'h0000;
    logic             wr    = 1'b0;
    logic             rd    = 1'b0;
    logic [9:0]       ev    = 10'h000;
    logic             clr   = 1'b1;
    logic             en    = 1'b1;
    logic [15:0]      rdata;
    logic [2:0]       led;
    logic [2:0][15:0] lit;
    int               fails   = 0;
    int               n_tests = 0;
    int               cyc     = 0;

    always #4 clk = ~clk;

    lfe_top #(.FAST_BASE(FB), .SLOW_BASE(SB)) i_lfe_top (
        .core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata),
        .link_up_slow_speed_i(ev[0]), .link_up_mid_speed_i(ev[1]),
        .link_up_gigabit_i(ev[2]), .transmit_activity_i(ev[3]),
        .receive_activity_i(ev[4]), .collision_i(ev[5]),
        .eee_mode_i(ev[6]), .aneg_busy_i(ev[7]),
        .diag_active_i(ev[8]), .media_fiber_i(ev[9]), .led_o(led));

    lfe_led_model i_lfe_led_model (
        .core_clk_i(clk), .clr_i(clr), .led_i(led), .lit_cnt_o(lit));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic nclk(input int n);
        repeat (n) @(negedge clk);
    endtask : nclk

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
    endtask : rd_chk

    // skips two toggles, since a config change may cut a period short
    task automatic half(input int i, input int e);
        logic v;
        int   n;
        for (int j = 0; j < 3; j++) begin
            v = led[i];
            n = 0;
            while (led[i] === v && n < 300) begin
                @(negedge clk);
                n++;
            end
        end
        `CHK(n, e)
    endtask : half

    task automatic t_regs;
        logic [15:0] rv [8] = '{RST_LED_CFG, RST_LED_CFG, RST_LED_CFG,
            RST_COMPLEX_LO, RST_COMPLEX_HI, RST_LED_CTRL, 16'h0000, 16'h0000};
        logic [15:0] mv [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0003,
            16'h0FF1, 16'h0077, 16'h0000, 16'h0000};
        for (int a = 0; a < 8; a++) begin
            if (a != 6) begin
                rd_chk(4'(a), rv[a]);
                wr_reg(4'(a), 16'hFFFF);
                rd_chk(4'(a), mv[a]);
                wr_reg(4'(a), rv[a]);
            end
        end
    endtask : t_regs

    task automatic t_steady;
        for (int c = 1; c < 14; c++) begin
            wr_reg(ADDR_LED_CFG2, 16'(c) << POS_ON);
            @(posedge clk);
            ev <= 10'(1 << SRC_BIT[c-1]);
            nclk(5);
            `CHK(led, 3'b100)
            @(posedge clk);
            ev <= 10'h000;
            nclk(5);
            `CHK(led, 3'b000)
        end
    endtask : t_steady

    task automatic t_flash;
        wr_reg(ADDR_LED_CFG1, 16'h0020);
        wr_reg(ADDR_LED_CFG2, 16'h0100);
        @(posedge clk);
        ev <= 10'h003;
        for (int s = 0; s < 3; s++) begin
            wr_reg(ADDR_COMPLEX_HI, 16'(s) << POS_FFS | 16'(2 - s) << POS_SFS);
            half(1, FB << s);
            half(2, SB << (2 - s));
        end
    endtask : t_flash

    task automatic t_prio;
        wr_reg(ADDR_COMPLEX_HI, RST_COMPLEX_HI);
        wr_reg(ADDR_LED_CFG0, 16'h3120);
        @(posedge clk);
        ev <= 10'h004;
        nclk(5);
        `CHK(led[0], 1'b1)
        @(posedge clk);
        ev <= 10'h005;
        half(0, SB << 1);
        @(posedge clk);
        ev <= 10'h007;
        half(0, FB << 1);
    endtask : t_prio

    task automatic t_pulse;
        // LED0 pulses on tx as well, so the pulse checks in the block see traffic
        wr_reg(ADDR_LED_CFG0, 16'h0005);
        wr_reg(ADDR_LED_CFG1, 16'h3005);
        wr_reg(ADDR_LED_CFG2, 16'h0007);
        for (int k = 0; k < 2; k++) begin
            wr_reg(ADDR_COMPLEX_HI, 16'h0100 | 16'(1 - k) << POS_FFS);
            @(posedge clk);
            ev <= 10'h004;
            nclk(6);
            @(posedge clk);
            clr <= 1'b1;
            ev  <= 10'h00C;
            @(posedge clk);
            clr <= 1'b0;
            @(posedge clk);
            ev <= 10'h004;
            repeat (2) @(posedge clk);
            // second activity edge lands inside the running pulse
            ev <= 10'h014;
            repeat (6) @(posedge clk);
            ev <= 10'h004;
            repeat (40) @(posedge clk);
            nclk(1);
            `CHK(lit[2], 16'(FB << (1 - k)))
            `CHK(lit[1], 16'(49 - (FB << (1 - k))))
        end
    endtask : t_pulse

    task automatic walk_chk(input logic inv);
        logic [2:0] p;
        logic [2:0] q;
        logic [2:0] came;
        int         n;
        nclk(2);
        q    = led ^ {3{inv}};
        came = 3'b000;
        n    = -1000;
        for (int k = 0; k < 60; k++) begin
            nclk(1);
            p = led ^ {3{inv}};
            `CHK($onehot(p), 1'b1)
            if (p !== q) begin
                if (q != 3'b010) `CHK(p, 3'b010)
                else if (came != 3'b000) `CHK(p, came ^ 3'b101)
                if (n >= 0) `CHK(n, FB)
                came = (q == 3'b010) ? came : q;
                q    = p;
                n    = 0;
            end
            n++;
        end
    endtask : walk_chk

    task automatic t_complex;
        wr_reg(ADDR_COMPLEX_HI, 16'h0100);
        wr_reg(ADDR_COMPLEX_LO, 16'h0003);
        nclk(2);
        repeat (16) begin
            nclk(1);
            `CHK(led[2], led[0])
            `CHK(led[1], ~led[0])
        end
        half(0, FB);
        wr_reg(ADDR_COMPLEX_LO, 16'h0002);
        walk_chk(1'b0);
        wr_reg(ADDR_COMPLEX_HI, 16'h0101);
        walk_chk(1'b0);
        wr_reg(ADDR_COMPLEX_LO, 16'h0000);
        walk_chk(1'b1);
    endtask : t_complex

    task automatic t_ext;
        wr_reg(ADDR_COMPLEX_LO, 16'h0001);
        wr_reg(ADDR_LED_CTRL, 16'h0052);
        nclk(2);
        repeat (12) begin
            nclk(1);
            `CHK({led[2], led[0]}, 2'b11)
        end
        @(posedge clk);
        addr <= ADDR_STATUS;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        `CHK({rdata[6], rdata[4]}, 2'b11)
        half(1, FB);
        wr_reg(ADDR_LED_CTRL, 16'h0002);
        nclk(2);
        `CHK({led[2], led[0]}, 2'b00)
    endtask : t_ext

    // a low clock enable freezes dividers and outputs
    task automatic t_hold;
        logic [2:0] l;
        @(posedge clk);
        en <= 1'b0;
        nclk(2);
        l = led;
        nclk(20);
        `CHK(led, l)
        @(posedge clk);
        en <= 1'b1;
        half(1, FB);
    endtask : t_hold

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        nclk(2);
        `CHK(led, 3'b000)
        t_regs();
        t_steady();
        t_flash();
        t_prio();
        t_pulse();
        t_complex();
        t_ext();
        t_hold();
        give_verdict();
    end
endmodule : tb
